//--- shared/range_map_pkg.sv
/*
 * constants for the position-range mapping block: parameter numbers,
 * factory default values and range figures in base increments.
 * assumes base increments of 1/400 rotation at the output shaft.
 */
package range_map_pkg;
    localparam int unsigned PAR_W               = 8;
    localparam logic [7:0]  PAR_ACTUAL_SET      = 8'h0A;
    localparam logic [7:0]  PAR_DIRECTION       = 8'h1A;
    localparam logic [7:0]  PAR_NUMERATOR       = 8'h1C;
    localparam logic [7:0]  PAR_DENOMINATOR     = 8'h1E;
    localparam logic [7:0]  PAR_REF_OFFSET      = 8'h20;
    localparam logic [7:0]  PAR_TOP_MAPPING     = 8'h22;
    localparam logic [7:0]  PAR_UPPER_LIMIT     = 8'h24;
    localparam logic [7:0]  PAR_LOWER_LIMIT     = 8'h26;
    localparam logic [7:0]  PAR_WINDOW          = 8'h28;
    localparam logic [7:0]  PAR_LOOP_LENGTH     = 8'h2A;
    localparam logic [7:0]  PAR_FOLLOW_ERROR    = 8'h2C;
    localparam logic [7:0]  PAR_SAVE            = 8'h71;

    localparam logic signed [31:0] STEPS_PER_ROT    = 32'sh0000_0190; // 400
    localparam logic signed [31:0] MEASURE_ROTS     = 32'sh0000_0100; // 256
    localparam logic signed [31:0] COMMAND_ROTS     = 32'sh0000_00FA; // 250
    localparam logic signed [31:0] MARGIN_ROTS      = 32'sh0000_0003; // 3
    localparam logic signed [31:0] MEASURE_RANGE    = MEASURE_ROTS * STEPS_PER_ROT;
    localparam logic signed [31:0] TOP_MARGIN       = MARGIN_ROTS * STEPS_PER_ROT;
    localparam logic signed [31:0] BOTTOM_MARGIN    = (MARGIN_ROTS + COMMAND_ROTS) * STEPS_PER_ROT;

    localparam logic signed [31:0] RST_NUMERATOR    = 32'sh0000_0190;
    localparam logic signed [31:0] RST_DENOMINATOR  = 32'sh0000_0190;
    localparam logic signed [31:0] RST_REF_OFFSET   = 32'sh0000_0000;
    localparam logic signed [31:0] RST_TOP_MAPPING  = 32'sh0001_9000; // 102400
    localparam logic signed [31:0] RST_UPPER_LIMIT  = 32'sh0001_8B50; // 101200
    localparam logic signed [31:0] RST_LOWER_LIMIT  = 32'sh0000_04B0; // 1200
    localparam logic signed [31:0] RST_ACTUAL       = 32'sh0000_C800; // 51200
    localparam logic signed [31:0] RST_WINDOW       = 32'sh0000_0004;
    localparam logic signed [31:0] RST_LOOP_LENGTH  = -32'sh0000_00FA;
    localparam logic signed [31:0] RST_FOLLOW_ERROR = 32'sh0000_0190;
    localparam logic signed [31:0] SCALE_MIN        = 32'sh0000_0001;
    localparam logic signed [31:0] SCALE_MAX        = 32'sh0000_2710; // 10000
endpackage

//--- src/position_range_mapping.sv
/*
 * position-range mapping of an absolute-encoder drive: parameter store,
 * scaling, referencing, mapping end, travel limits and target check.
 * assumes i_phys_pos comes from encoder logic on i_clk, in 1/400 rotation,
 * and that the parameter channel and the storage engine run on i_clk.
 */
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
module position_range_mapping
    import range_map_pkg::*;
(
    input  wire logic                          i_clk,
    input  wire logic                          i_reset,
    input  wire logic                          i_par_write,
    input  wire logic                          i_par_read,
    input  wire logic [range_map_pkg::PAR_W-1:0] i_par_number,
    input  wire logic signed [31:0]            i_par_wdata,
    output logic                               o_par_ack,
    output logic                               o_par_error,
    output logic signed [31:0]                 o_par_rdata,
    input  wire logic signed [31:0]            i_phys_pos,
    input  wire logic                          i_target_write,
    input  wire logic signed [31:0]            i_target_value,
    output logic                               o_target_accept,
    output logic                               o_target_reject,
    output logic signed [31:0]                 o_target_raw,
    output logic signed [31:0]                 o_actual_position,
    output logic                               o_direction,
    output logic                               o_save_request,
    input  wire logic                          i_save_done
);
    import range_map_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // stored state, all positions in base increments, reference excluded
    logic               direction_reg;
    logic signed [31:0] numerator_reg;
    logic signed [31:0] denominator_reg;
    logic signed [31:0] ref_raw_reg;
    logic signed [31:0] top_raw_reg;
    logic signed [31:0] upper_raw_reg;
    logic signed [31:0] lower_raw_reg;
    logic signed [31:0] window_raw_reg;
    logic signed [31:0] loop_raw_reg;
    logic signed [31:0] follow_raw_reg;
    logic signed [31:0] target_raw_reg;
    logic               save_reg;

    // raw increments to user units
    function automatic logic signed [31:0] to_user(input logic signed [31:0] raw,
                                                   input logic signed [31:0] num,
                                                   input logic signed [31:0] den);
        logic signed [63:0] prod;
        prod = 64'(raw) * 64'(den);
        return 32'(prod / 64'(num));
    endfunction

    // user units to raw increments
    function automatic logic signed [31:0] to_raw(input logic signed [31:0] usr,
                                                  input logic signed [31:0] num,
                                                  input logic signed [31:0] den);
        logic signed [63:0] prod;
        prod = 64'(usr) * 64'(num);
        return 32'(prod / 64'(den));
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // derived values
    logic signed [31:0] phys_dir;
    logic signed [31:0] wr_raw;
    logic signed [31:0] actual_user;
    logic signed [31:0] cand_top;
    logic signed [31:0] cand_upper_user;
    logic signed [31:0] cand_lower_user;
    logic signed [31:0] tgt_raw;
    logic               wr_hit;
    logic               top_ok;
    logic               scale_ok;
    logic               limit_ok;
    logic               tgt_ok;

    assign phys_dir    = direction_reg ? (MEASURE_RANGE - i_phys_pos) : i_phys_pos;
    assign actual_user = to_user(phys_dir + ref_raw_reg, numerator_reg,
                                 denominator_reg);
    assign wr_raw      = to_raw(i_par_wdata, numerator_reg, denominator_reg);
    assign cand_top    = wr_raw - ref_raw_reg;
    assign cand_upper_user = to_user(cand_top - TOP_MARGIN + ref_raw_reg,
                                     numerator_reg, denominator_reg);
    assign cand_lower_user = to_user(cand_top - BOTTOM_MARGIN + ref_raw_reg,
                                     numerator_reg, denominator_reg);
    // window for the mapping end is actual +3 to +253 rotations
    assign top_ok   = (cand_lower_user - 32'sh0000_0001 <= actual_user) &&
                      (actual_user <= cand_upper_user + 32'sh0000_0001);
    assign scale_ok = (i_par_wdata >= SCALE_MIN) && (i_par_wdata <= SCALE_MAX);
    // limits may only be narrowed inside the commandable 250 rotations
    assign limit_ok = (cand_top >= top_raw_reg - BOTTOM_MARGIN) &&
                      (cand_top <= top_raw_reg - TOP_MARGIN);
    assign wr_hit   = i_par_write;
    assign tgt_raw  = to_raw(i_target_value, numerator_reg, denominator_reg) - ref_raw_reg;
    assign tgt_ok   = (tgt_raw >= lower_raw_reg) && (tgt_raw <= upper_raw_reg);

    function automatic logic write_refused(input logic [7:0] num_in,
                                           input logic top_good,
                                           input logic scale_good,
                                           input logic limit_good);
        unique case (num_in)
            PAR_TOP_MAPPING:                    return !top_good;
            PAR_NUMERATOR, PAR_DENOMINATOR:     return !scale_good;
            PAR_UPPER_LIMIT, PAR_LOWER_LIMIT:   return !limit_good;
            PAR_ACTUAL_SET, PAR_DIRECTION, PAR_REF_OFFSET, PAR_WINDOW,
            PAR_LOOP_LENGTH, PAR_FOLLOW_ERROR, PAR_SAVE: return 1'b0;
            default:                            return 1'b1;
        endcase
    endfunction

    logic wr_ok;
    assign wr_ok = wr_hit && !write_refused(i_par_number, top_ok, scale_ok, limit_ok);

    //////////////////////////////////////////////////////////////////////////
    // direction and scaling
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            direction_reg   <= 1'b0;
            numerator_reg   <= RST_NUMERATOR;
            denominator_reg <= RST_DENOMINATOR;
        end else if (wr_ok) begin
            if (i_par_number == PAR_DIRECTION)
                direction_reg <= i_par_wdata[0];
            if (i_par_number == PAR_NUMERATOR)
                numerator_reg <= i_par_wdata;
            if (i_par_number == PAR_DENOMINATOR)
                denominator_reg <= i_par_wdata;
        end
    end

    // reference offset, mapping end and limits; values are kept raw so a
    // scaling or reference change re-derives every user value on read
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ref_raw_reg   <= RST_REF_OFFSET;
            top_raw_reg   <= RST_TOP_MAPPING;
            upper_raw_reg <= RST_UPPER_LIMIT;
            lower_raw_reg <= RST_LOWER_LIMIT;
        end else if (wr_ok) begin
            unique case (i_par_number)
                PAR_DIRECTION: begin
                    if (i_par_wdata[0] != direction_reg) begin
                        ref_raw_reg   <= RST_REF_OFFSET;
                        top_raw_reg   <= RST_TOP_MAPPING;
                        upper_raw_reg <= RST_UPPER_LIMIT;
                        lower_raw_reg <= RST_LOWER_LIMIT;
                    end
                end
                PAR_REF_OFFSET:
                    ref_raw_reg <= wr_raw;
                PAR_ACTUAL_SET:
                    ref_raw_reg <= wr_raw - phys_dir;
                PAR_TOP_MAPPING: begin
                    top_raw_reg   <= cand_top;
                    upper_raw_reg <= cand_top - TOP_MARGIN;
                    lower_raw_reg <= cand_top - BOTTOM_MARGIN;
                end
                PAR_UPPER_LIMIT:
                    upper_raw_reg <= cand_top;
                PAR_LOWER_LIMIT:
                    lower_raw_reg <= cand_top;
                default: ;
            endcase
        end
    end

    // magnitudes: window, loop length, following error
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            window_raw_reg <= RST_WINDOW;
            loop_raw_reg   <= RST_LOOP_LENGTH;
            follow_raw_reg <= RST_FOLLOW_ERROR;
        end else if (wr_ok) begin
            if (i_par_number == PAR_WINDOW)
                window_raw_reg <= wr_raw;
            if (i_par_number == PAR_LOOP_LENGTH)
                loop_raw_reg <= wr_raw;
            if (i_par_number == PAR_FOLLOW_ERROR)
                follow_raw_reg <= wr_raw;
        end
    end

    // save request, a new request wins over a completion in the same cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset)
            save_reg <= 1'b0;
        else if (wr_ok && i_par_number == PAR_SAVE && i_par_wdata == 32'sh0000_0001)
            save_reg <= 1'b1;
        else if (i_save_done)
            save_reg <= 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // parameter channel answer, one cycle after the request
    logic signed [31:0] rdata_next;
    always_comb begin
        unique case (i_par_number)
            PAR_ACTUAL_SET:   rdata_next = actual_user;
            PAR_DIRECTION:    rdata_next = {31'h0, direction_reg};
            PAR_NUMERATOR:    rdata_next = numerator_reg;
            PAR_DENOMINATOR:  rdata_next = denominator_reg;
            PAR_REF_OFFSET:   rdata_next = to_user(ref_raw_reg, numerator_reg,
                                                   denominator_reg);
            PAR_TOP_MAPPING:  rdata_next = to_user(top_raw_reg + ref_raw_reg,
                                                   numerator_reg, denominator_reg);
            PAR_UPPER_LIMIT:  rdata_next = to_user(upper_raw_reg + ref_raw_reg,
                                                   numerator_reg, denominator_reg);
            PAR_LOWER_LIMIT:  rdata_next = to_user(lower_raw_reg + ref_raw_reg,
                                                   numerator_reg, denominator_reg);
            PAR_WINDOW:       rdata_next = to_user(window_raw_reg, numerator_reg,
                                                   denominator_reg);
            PAR_LOOP_LENGTH:  rdata_next = to_user(loop_raw_reg, numerator_reg,
                                                   denominator_reg);
            PAR_FOLLOW_ERROR: rdata_next = to_user(follow_raw_reg, numerator_reg,
                                                   denominator_reg);
            PAR_SAVE:         rdata_next = {31'h0, save_reg};
            default:          rdata_next = 32'sh0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_par_ack   <= 1'b0;
            o_par_error <= 1'b0;
            o_par_rdata <= 32'sh0000_0000;
        end else begin
            o_par_ack   <= i_par_write || i_par_read;
            o_par_error <= wr_hit && !wr_ok;
            o_par_rdata <= (i_par_write || i_par_read) ? rdata_next : o_par_rdata;
        end
    end

    // positioning target check
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_target_accept <= 1'b0;
            o_target_reject <= 1'b0;
            target_raw_reg  <= RST_ACTUAL;
        end else begin
            o_target_accept <= i_target_write && tgt_ok;
            o_target_reject <= i_target_write && !tgt_ok;
            if (i_target_write && tgt_ok)
                target_raw_reg <= tgt_raw;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset)
            o_actual_position <= RST_ACTUAL;
        else
            o_actual_position <= actual_user;
    end

    assign o_target_raw   = target_raw_reg;
    assign o_direction    = direction_reg;
    assign o_save_request = save_reg;

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_window_width: assert property (@(posedge i_clk) disable iff (i_reset)
        upper_raw_reg - lower_raw_reg <= BOTTOM_MARGIN - TOP_MARGIN)
        else $error("travel window wider than 250 rotations");
    a_end_sets_limits: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_ok && i_par_number == PAR_TOP_MAPPING |=>
        upper_raw_reg == top_raw_reg - TOP_MARGIN &&
        lower_raw_reg == top_raw_reg - BOTTOM_MARGIN)
        else $error("limits not derived from mapping end");
    a_dir_defaults: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_ok && i_par_number == PAR_DIRECTION && i_par_wdata[0] != direction_reg |=>
        top_raw_reg == RST_TOP_MAPPING && ref_raw_reg == RST_REF_OFFSET &&
        upper_raw_reg == RST_UPPER_LIMIT && lower_raw_reg == RST_LOWER_LIMIT)
        else $error("direction change left values changed");
    a_scale_range: assert property (@(posedge i_clk) disable iff (i_reset)
        numerator_reg >= SCALE_MIN && numerator_reg <= SCALE_MAX &&
        denominator_reg >= SCALE_MIN && denominator_reg <= SCALE_MAX)
        else $error("scaling factor out of range");
    a_end_refused: assert property (@(posedge i_clk) disable iff (i_reset)
        i_par_write && i_par_number == PAR_TOP_MAPPING && !top_ok |=>
        o_par_error && $stable(top_raw_reg))
        else $error("bad mapping end taken");
    a_target_reject: assert property (@(posedge i_clk) disable iff (i_reset)
        i_target_write && (tgt_raw > upper_raw_reg || tgt_raw < lower_raw_reg) |=>
        o_target_reject && !o_target_accept && $stable(target_raw_reg))
        else $error("target in margin not rejected");
    a_actual_ref: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_ok && i_par_number == PAR_ACTUAL_SET |=>
        ref_raw_reg == $past(wr_raw) - $past(phys_dir))
        else $error("actual write did not set reference");
    a_save_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        save_reg && !i_save_done |=> save_reg)
        else $error("save flag dropped before completion");
    a_save_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        i_save_done && !(i_par_write && i_par_number == PAR_SAVE) |=> !save_reg)
        else $error("save flag not cleared");
    a_ref_write: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_ok && i_par_number == PAR_REF_OFFSET |=> ref_raw_reg == $past(wr_raw))
        else $error("reference write lost");
endmodule // position_range_mapping

//--- bench/nv_store_model.sv
/*
 * storage engine model: answers a pending save request after a few cycles.
 * assumes it shares the clock and reset of the mapping block.
 */
`timescale 1ns/10ps
module nv_store_model (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_request,
    output logic      o_done
);
    int cnt;
    // storing takes six cycles, then done is raised once
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt    <= 0;
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt == 5);
            cnt    <= i_request ? cnt + 1 : 0;
        end
    end
endmodule // nv_store_model

//--- bench/test_position_range_mapping.sv
/*
 * self-checking bench of the mapping block against an integer model.
 * assumes default scaling 400/400 and a physical position held at 51200.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin error_cnt++; \
    $display("MISMATCH %s expected %0d seen %0d", nm, ex, got); end end
module test_position_range_mapping;
    import range_map_pkg::*;
    logic i_clk, i_reset, i_par_write, i_par_read, i_target_write, i_save_done;
    logic [PAR_W-1:0] i_par_number;
    logic signed [31:0] i_par_wdata, i_phys_pos, i_target_value;
    logic o_par_ack, o_par_error, o_target_accept, o_target_reject, o_direction, o_save_request;
    logic signed [31:0] o_par_rdata, o_target_raw, o_actual_position;
    int error_cnt, checks_done, ref_m, end_m, up_m, lo_m, v;
    position_range_mapping position_range_mapping_i (.i_clk(i_clk), .i_reset(i_reset),
        .i_par_write(i_par_write), .i_par_read(i_par_read), .i_par_number(i_par_number),
        .i_par_wdata(i_par_wdata), .o_par_ack(o_par_ack), .o_par_error(o_par_error),
        .o_par_rdata(o_par_rdata), .i_phys_pos(i_phys_pos), .i_target_write(i_target_write),
        .i_target_value(i_target_value), .o_target_accept(o_target_accept),
        .o_target_reject(o_target_reject), .o_target_raw(o_target_raw),
        .o_actual_position(o_actual_position), .o_direction(o_direction),
        .o_save_request(o_save_request), .i_save_done(i_save_done));
    nv_store_model nv_store_model_i (.i_clk(i_clk), .i_reset(i_reset),
        .i_request(o_save_request), .o_done(i_save_done));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic par(input logic w, input logic [7:0] n, input int d, input logic er);
        @(negedge i_clk);
        i_par_write = w; i_par_read = !w; i_par_number = n; i_par_wdata = d;
        @(negedge i_clk);
        i_par_write = 1'b0; i_par_read = 1'b0;
        `CHK("ack", 1'b1, o_par_ack)
        `CHK("error", er, o_par_error)
    endtask
    task automatic rd(input logic [7:0] n, input int ex);
        par(1'b0, n, 0, 1'b0);
        `CHK("read", ex, o_par_rdata)
    endtask
    task automatic check_all();
        rd(PAR_TOP_MAPPING, end_m);
        rd(PAR_UPPER_LIMIT, up_m);
        rd(PAR_LOWER_LIMIT, lo_m);
        rd(PAR_REF_OFFSET, ref_m);
        `CHK("actual", 51200 + ref_m, o_actual_position)
    endtask
    task automatic set_end(input int e);
        end_m = e; up_m = e - 1200; lo_m = e - 101200;
        par(1'b1, PAR_TOP_MAPPING, e, 1'b0);
    endtask
    task automatic shift(input int d);
        ref_m += d; end_m += d; up_m += d; lo_m += d;
    endtask
    task automatic tgt(input int t, input logic ok);
        @(negedge i_clk);
        i_target_write = 1'b1; i_target_value = t;
        @(negedge i_clk);
        i_target_write = 1'b0;
        `CHK("accept", ok, o_target_accept)
        `CHK("reject", !ok, o_target_reject)
        if (ok) `CHK("target raw", t - ref_m, o_target_raw)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {i_par_write, i_par_read, i_target_write, i_par_number} = '0;
        {i_par_wdata, i_target_value} = '0;
        i_phys_pos = 32'sh0000_C800;
        error_cnt = 0; checks_done = 0;
        ref_m = 0; end_m = 102400; up_m = 101200; lo_m = 1200;
        void'($urandom(32'hB736));
        i_reset = 1'b1;
        repeat (10) @(posedge i_clk);
        @(negedge i_clk);
        i_reset = 1'b0;
        check_all();
        `CHK("target reset", 51200, o_target_raw)
        rd(PAR_NUMERATOR, 400);
        rd(PAR_DENOMINATOR, 400);
        for (int i = 0; i < 2; i++)
            par(1'b1, PAR_NUMERATOR, i ? 10001 : 0, 1'b1);
        par(1'b1, PAR_DENOMINATOR, 0, 1'b1);
        par(1'b1, PAR_TOP_MAPPING, 52398, 1'b1);
        set_end(52400);
        check_all();
        par(1'b1, PAR_TOP_MAPPING, 152402, 1'b1);
        set_end(152400);
        check_all();
        par(1'b1, PAR_UPPER_LIMIT, up_m + 1, 1'b1);
        par(1'b1, PAR_UPPER_LIMIT, up_m - 400, 1'b0);
        up_m -= 400;
        tgt(up_m + 1, 1'b0);
        tgt(up_m, 1'b1);
        tgt(lo_m - 1, 1'b0);
        tgt(lo_m, 1'b1);
        v = $urandom_range(5000, 1);
        par(1'b1, PAR_REF_OFFSET, v, 1'b0);
        shift(v);
        check_all();
        set_end(end_m);
        check_all();
        tgt(lo_m + $urandom_range(99999, 0), 1'b1);
        v = $urandom_range(90000, 1000);
        par(1'b1, PAR_ACTUAL_SET, 51200 + v, 1'b0);
        shift(v - ref_m);
        check_all();
        par(1'b1, PAR_DIRECTION, 1, 1'b0);
        ref_m = 0; end_m = 102400; up_m = 101200; lo_m = 1200;
        `CHK("direction", 1'b1, o_direction)
        check_all();
        par(1'b1, PAR_NUMERATOR, 200, 1'b0);
        rd(PAR_TOP_MAPPING, 204800);
        rd(PAR_LOWER_LIMIT, 2400);
        rd(PAR_WINDOW, 8);
        rd(PAR_FOLLOW_ERROR, 800);
        rd(PAR_LOOP_LENGTH, -500);
        `CHK("actual scaled", 102400, o_actual_position)
        par(1'b1, PAR_NUMERATOR, 400, 1'b0);
        rd(PAR_UPPER_LIMIT, 101200);
        par(1'b1, PAR_SAVE, 1, 1'b0);
        `CHK("save pending", 1'b1, o_save_request)
        v = 0;
        do begin
            par(1'b0, PAR_SAVE, 0, 1'b0);
            v++;
        end while (o_par_rdata !== 0 && v < 40);
        `CHK("save cleared", 0, o_par_rdata)
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule // test_position_range_mapping
